// *** design/ccoc_channel.sv ***
// One channel: programmable divider with a start-up phase delay.
// Assumes restart is a one-cycle pulse from the register file.
`timescale 1ns/1ns
module ccoc_channel (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] divider_code,
  input  wire logic [7:0] phase_code,
  input  wire logic       power_down,
  input  wire logic       restart,
  output logic            chan_clk,
  output logic            running
);

  ccoc_pkg::ccoc_state_t state;
  ccoc_pkg::ccoc_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_chan_clk;
  logic [7:0] ratio;
  logic [7:0] hold;

  assign ratio = ccoc_pkg::divider_ratio(divider_code);
  assign running = (state == ccoc_pkg::CCOC_RUN);

  // Half period is ratio cycles; a new setting restarts the phase
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_chan_clk = chan_clk;
    if (power_down) begin
      next_state    = ccoc_pkg::CCOC_OFF;
      next_chan_clk = 1'b0;
    end else if (restart || state == ccoc_pkg::CCOC_OFF) begin
      next_state    = ccoc_pkg::CCOC_DELAY;
      next_cnt      = ccoc_pkg::phase_cycles(phase_code);
      next_chan_clk = 1'b0;
    end else begin
      case (state)
        ccoc_pkg::CCOC_DELAY: begin
          if (cnt == 8'h00) begin
            next_state = ccoc_pkg::CCOC_RUN;
            next_cnt   = ratio - 8'h01;
          end else begin
            next_cnt = cnt - 8'h01;
          end
        end
        default: begin
          if (cnt == 8'h00) begin
            next_chan_clk = ~chan_clk;
            next_cnt      = ratio - 8'h01;
          end else begin
            next_cnt = cnt - 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state    <= ccoc_pkg::CCOC_OFF;
      cnt      <= 8'h00;
      chan_clk <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      chan_clk <= next_chan_clk;
    end
  end

  // Helper: cycles the divided clock has held its level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold <= 8'h00;
    end else if (next_chan_clk != chan_clk || state != ccoc_pkg::CCOC_RUN) begin
      hold <= 8'h00;
    end else begin
      hold <= hold + 8'h01;
    end
  end

  sequence pd_seen_s;
    power_down;
  endsequence

  half_period_a: assert property (@(posedge clk) disable iff (reset)
    (running && !power_down && !restart && $past(running) && $changed(chan_clk)
     && $past(hold) != 8'h00 ##0 1'b1) |-> ($past(hold) + 8'h01 == ratio))
    else $error("divided clock half period differs from ratio");

  chan_off_a: assert property (@(posedge clk) disable iff (reset)
    pd_seen_s |=> (!chan_clk && state == ccoc_pkg::CCOC_OFF))
    else $error("powered-down channel still toggles");

  phase_load_a: assert property (@(posedge clk) disable iff (reset)
    (restart && !power_down) |=> (state == ccoc_pkg::CCOC_DELAY
      && cnt == ccoc_pkg::phase_cycles($past(phase_code)) && !chan_clk))
    else $error("phase delay not loaded on restart");

endmodule // ccoc_channel

// *** design/ccoc_pkg.sv ***
// Package for the channel and clock output configuration block.
// Assumes a single 50 MHz clock; offsets are byte addresses on an
// 8-bit register port.
package ccoc_pkg;

  // Structure
  localparam int CH_COUNT  = 5;
  localparam int OUT_COUNT = 10;

  // Register map: channel groups sit at 0x20, 0x30 .. 0x60
  localparam logic [3:0] CH_NIB_FIRST  = 4'h2;
  localparam logic [3:0] CH_NIB_LAST   = 4'h6;
  localparam logic [3:0] OFS_DIVIDER   = 4'h0;
  localparam logic [3:0] OFS_PHASE     = 4'h1;
  localparam logic [3:0] OFS_CH_PD     = 4'h2;
  localparam logic [3:0] OFS_OUT_FIRST = 4'h4;
  localparam logic [7:0] ADDR_EN_LO    = 8'h74;
  localparam logic [7:0] ADDR_EN_HI    = 8'h75;
  localparam logic [7:0] ADDR_STATUS   = 8'h7F;

  // Field positions
  localparam int PD_BIT    = 7;
  localparam int STYLE_BIT = 4;
  localparam int AMP_LSB   = 2;
  localparam int EN_LO_CNT = 8;

  // Reset values
  localparam logic [7:0] DIVIDER_RESET = 8'h04;
  localparam logic [7:0] PHASE_RESET   = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // Timing
  localparam int CLK_PERIOD_PS = 20000;
  localparam int PHASE_STEP_PS = 339;

  // Divider code to ratio; unlisted codes fall back to the reset ratio
  function automatic logic [7:0] divider_ratio(input logic [7:0] code);
    case (code)
      8'h80: divider_ratio = 8'd1;
      8'h00: divider_ratio = 8'd2;
      8'h01: divider_ratio = 8'd3;
      8'h02: divider_ratio = 8'd4;
      8'h03: divider_ratio = 8'd5;
      8'h06: divider_ratio = 8'd8;
      8'h43: divider_ratio = 8'd10;
      8'h44: divider_ratio = 8'd12;
      8'h46: divider_ratio = 8'd16;
      8'h4B: divider_ratio = 8'd20;
      8'h4C: divider_ratio = 8'd24;
      8'h53: divider_ratio = 8'd30;
      8'h4E: divider_ratio = 8'd32;
      8'h54: divider_ratio = 8'd36;
      8'h5B: divider_ratio = 8'd40;
      8'h56: divider_ratio = 8'd48;
      8'h63: divider_ratio = 8'd50;
      8'h64: divider_ratio = 8'd60;
      8'h5E: divider_ratio = 8'd64;
      8'h5F: divider_ratio = 8'd72;
      8'h66: divider_ratio = 8'd80;
      8'h6E: divider_ratio = 8'd96;
      8'h7B: divider_ratio = 8'd100;
      8'h7C: divider_ratio = 8'd120;
      8'h76: divider_ratio = 8'd128;
      8'h7E: divider_ratio = 8'd160;
      default: divider_ratio = 8'd6;
    endcase
  endfunction

  // Phase code to whole clock cycles of delay (truncated)
  function automatic logic [7:0] phase_cycles(input logic [7:0] code);
    int prod;
    prod = (int'(code) * PHASE_STEP_PS) / CLK_PERIOD_PS;
    phase_cycles = prod[7:0];
  endfunction

  // First output index and output count of each channel
  function automatic logic [3:0] out_base(input logic [2:0] ch);
    case (ch)
      3'h0: out_base = 4'h0;
      3'h1: out_base = 4'h3;
      3'h2: out_base = 4'h5;
      3'h3: out_base = 4'h7;
      default: out_base = 4'h8;
    endcase
  endfunction

  function automatic logic [3:0] out_count(input logic [2:0] ch);
    case (ch)
      3'h0: out_count = 4'h3;
      3'h3: out_count = 4'h1;
      3'h5, 3'h6, 3'h7: out_count = 4'h0;
      default: out_count = 4'h2;
    endcase
  endfunction

  // Channel feeding a given output
  function automatic logic [2:0] out_channel(input logic [3:0] idx);
    if (idx < 4'h3) begin
      out_channel = 3'h0;
    end else if (idx < 4'h5) begin
      out_channel = 3'h1;
    end else if (idx < 4'h7) begin
      out_channel = 3'h2;
    end else if (idx < 4'h8) begin
      out_channel = 3'h3;
    end else begin
      out_channel = 3'h4;
    end
  endfunction

  typedef enum logic [1:0] {CCOC_OFF, CCOC_DELAY, CCOC_RUN} ccoc_state_t;

endpackage

// *** design/ccoc_top.sv ***
// Channel and clock output configuration: register file, five channel
// dividers and ten gated clock outputs.
// Assumes a synchronous 8-bit register port driven from the same clk.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module ccoc_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  output logic      [9:0]  clock_output,
  output logic      [9:0]  output_power_down,
  output logic      [9:0]  output_format,
  output logic      [19:0] output_amplitude,
  output logic      [4:0]  channel_power_down
);

  localparam int NC = ccoc_pkg::CH_COUNT;
  localparam int NO = ccoc_pkg::OUT_COUNT;

  logic [7:0]  divider    [NC];
  logic [7:0]  phase      [NC];
  logic [7:0]  next_divider [NC];
  logic [7:0]  next_phase   [NC];
  logic [4:0]  next_ch_pd;
  logic [9:0]  out_pd;
  logic [9:0]  next_out_pd;
  logic [9:0]  next_format;
  logic [19:0] next_amp;
  logic [9:0]  out_en;
  logic [9:0]  next_out_en;
  logic [4:0]  restart;
  logic [4:0]  next_restart;
  logic [7:0]  next_rdata;
  logic [9:0]  next_clock_output;
  logic [4:0]  ch_clk;
  logic [4:0]  ch_run;

  logic [3:0]  nib;
  logic [3:0]  low;
  logic [2:0]  ch;
  logic        ch_hit;
  logic [3:0]  oslot;
  logic        out_hit;
  logic [3:0]  oi;

  // Address split shared by write and read decode
  assign nib     = reg_addr[7:4];
  assign low     = reg_addr[3:0];
  assign ch      = 3'(nib - ccoc_pkg::CH_NIB_FIRST);
  assign ch_hit  = nib >= ccoc_pkg::CH_NIB_FIRST
                   && nib <= ccoc_pkg::CH_NIB_LAST;
  assign oslot   = low - ccoc_pkg::OFS_OUT_FIRST;
  assign out_hit = ch_hit && low >= ccoc_pkg::OFS_OUT_FIRST
                   && oslot < ccoc_pkg::out_count(ch);
  assign oi      = ccoc_pkg::out_base(ch) + oslot;

  // Register writes; a divider or phase write restarts that channel a
  // cycle later, so the channel already sees the new code when it reloads
  always_comb begin
    next_divider = divider;
    next_phase   = phase;
    next_ch_pd   = channel_power_down;
    next_out_pd  = out_pd;
    next_format  = output_format;
    next_amp     = output_amplitude;
    next_out_en  = out_en;
    next_restart = 5'h00;
    if (reg_write) begin
      if (ch_hit && low == ccoc_pkg::OFS_DIVIDER) begin
        next_divider[ch] = reg_wdata;
        next_restart[ch] = 1'b1;
      end else if (ch_hit && low == ccoc_pkg::OFS_PHASE) begin
        next_phase[ch] = reg_wdata;
        next_restart[ch] = 1'b1;
      end else if (ch_hit && low == ccoc_pkg::OFS_CH_PD) begin
        next_ch_pd[ch] = reg_wdata[ccoc_pkg::PD_BIT];
      end else if (out_hit) begin
        next_out_pd[oi] = reg_wdata[ccoc_pkg::PD_BIT];
        next_format[oi] = reg_wdata[ccoc_pkg::STYLE_BIT];
        next_amp[2*oi +: 2] = reg_wdata[ccoc_pkg::AMP_LSB +: 2];
      end else if (reg_addr == ccoc_pkg::ADDR_EN_LO) begin
        for (int i = 0; i < ccoc_pkg::EN_LO_CNT; i++) begin
          next_out_en[i] = reg_wdata[7-i];
        end
      end else if (reg_addr == ccoc_pkg::ADDR_EN_HI) begin
        next_out_en[8] = reg_wdata[0];
        next_out_en[9] = reg_wdata[1];
      end
    end
  end

  // Register file; reset values as the power-up defaults
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < NC; c++) begin
        divider[c] <= ccoc_pkg::DIVIDER_RESET;
        phase[c]   <= ccoc_pkg::PHASE_RESET;
      end
      channel_power_down <= 5'h00;
      out_pd             <= 10'h000;
      output_format      <= 10'h000;
      output_amplitude   <= 20'h00000;
      out_en             <= 10'h000;
      restart            <= 5'h00;
    end else begin
      divider            <= next_divider;
      phase              <= next_phase;
      channel_power_down <= next_ch_pd;
      out_pd             <= next_out_pd;
      output_format      <= next_format;
      output_amplitude   <= next_amp;
      out_en             <= next_out_en;
      restart            <= next_restart;
    end
  end

  // Read mux; data stand only in the cycle after the strobe
  always_comb begin
    next_rdata = ccoc_pkg::READ_ZERO;
    if (reg_read) begin
      if (ch_hit && low == ccoc_pkg::OFS_DIVIDER) begin
        next_rdata = divider[ch];
      end else if (ch_hit && low == ccoc_pkg::OFS_PHASE) begin
        next_rdata = phase[ch];
      end else if (ch_hit && low == ccoc_pkg::OFS_CH_PD) begin
        next_rdata[ccoc_pkg::PD_BIT] = channel_power_down[ch];
      end else if (out_hit) begin
        next_rdata[ccoc_pkg::PD_BIT]     = out_pd[oi];
        next_rdata[ccoc_pkg::STYLE_BIT]  = output_format[oi];
        next_rdata[ccoc_pkg::AMP_LSB +: 2] = output_amplitude[2*oi +: 2];
      end else if (reg_addr == ccoc_pkg::ADDR_EN_LO) begin
        for (int i = 0; i < ccoc_pkg::EN_LO_CNT; i++) begin
          next_rdata[7-i] = out_en[i];
        end
      end else if (reg_addr == ccoc_pkg::ADDR_EN_HI) begin
        next_rdata[1:0] = out_en[9:8];
      end else if (reg_addr == ccoc_pkg::ADDR_STATUS) begin
        next_rdata[4:0] = ch_run; // Live channel run state
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // One divider per channel
  for (genvar g = 0; g < NC; g++) begin : g_ch
    ccoc_channel u_channel (
      .clk          (clk),
      .reset        (reset),
      .divider_code (divider[g]),
      .phase_code   (phase[g]),
      .power_down   (channel_power_down[g]),
      .restart      (restart[g]),
      .chan_clk     (ch_clk[g]),
      .running      (ch_run[g])
    );
  end

  // Output gating; a disabled or powered-down output rests low
  always_comb begin
    for (int i = 0; i < NO; i++) begin
      next_clock_output[i] = out_en[i]
        && !out_pd[i]
        && !channel_power_down[ccoc_pkg::out_channel(4'(i))]
        && ch_clk[ccoc_pkg::out_channel(4'(i))];
    end
  end

  // Power-down seen by the output driver merges both levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clock_output      <= 10'h000;
      output_power_down <= 10'h000;
    end else begin
      clock_output <= next_clock_output;
      for (int i = 0; i < NO; i++) begin
        output_power_down[i] <= out_pd[i]
          || channel_power_down[ccoc_pkg::out_channel(4'(i))];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence out_pd_write_s;
    reg_write && out_hit && reg_wdata[ccoc_pkg::PD_BIT];
  endsequence

  sequence en_lo_clear_s;
    reg_write && reg_addr == ccoc_pkg::ADDR_EN_LO && reg_wdata == 8'h00;
  endsequence

  sequence ch_pd_write_s;
    reg_write && ch_hit && low == ccoc_pkg::OFS_CH_PD
      && reg_wdata[ccoc_pkg::PD_BIT];
  endsequence

  out_power_down_a: assert property (
    out_pd_write_s ##1 (out_pd[$past(oi)] && !out_en[$past(oi)] == 1'b0)
      |=> !clock_output[$past(oi, 2)] && output_power_down[$past(oi, 2)])
    else $error("powered-down output still drives");

  enable_low_a: assert property (
    en_lo_clear_s ##1 1'b1 |=> clock_output[7:0] == 8'h00 [*3])
    else $error("disabled outputs not held low");

  chan_pd_outputs_a: assert property (
    ch_pd_write_s |-> ##2 (clock_output[ccoc_pkg::out_base($past(ch, 2))] == 1'b0
      && channel_power_down[$past(ch, 2)]))
    else $error("outputs of powered-down channel toggle");

  format_write_a: assert property (
    reg_write && out_hit |=> output_format[$past(oi)]
      == $past(reg_wdata[ccoc_pkg::STYLE_BIT]))
    else $error("format select not stored");

  amp_write_a: assert property (
    reg_write && out_hit |=> output_amplitude[2*$past(oi) +: 2]
      == $past(reg_wdata[ccoc_pkg::AMP_LSB +: 2]))
    else $error("amplitude field not stored");

  divider_store_a: assert property (
    reg_write && ch_hit && low == ccoc_pkg::OFS_DIVIDER
      |=> divider[$past(ch)] == $past(reg_wdata) && restart[$past(ch)])
    else $error("divider code not stored or channel not restarted");

  phase_store_a: assert property (
    reg_write && ch_hit && low == ccoc_pkg::OFS_PHASE
      |=> phase[$past(ch)] == $past(reg_wdata) ##1 !ch_run[$past(ch, 2)])
    else $error("phase code not stored or channel not restarted");

  ch_pd_store_a: assert property (
    reg_write && ch_hit && low == ccoc_pkg::OFS_CH_PD
      |=> channel_power_down[$past(ch)]
        == $past(reg_wdata[ccoc_pkg::PD_BIT]))
    else $error("channel power-down bit not stored");

  en_hi_store_a: assert property (
    reg_write && reg_addr == ccoc_pkg::ADDR_EN_HI
      |=> out_en[9:8] == $past(reg_wdata[1:0]))
    else $error("upper output enables not stored");

  // Read data must not linger past the reply cycle
  rdata_idle_a: assert property (
    !reg_read |=> reg_rdata == ccoc_pkg::READ_ZERO)
    else $error("read data outside the reply cycle");

  divider_read_a: assert property (
    reg_read && ch_hit && low == ccoc_pkg::OFS_DIVIDER
      |=> reg_rdata == $past(divider[ch]))
    else $error("divider code read back wrong");

  out_reg_read_a: assert property (
    reg_read && out_hit
      |=> reg_rdata[ccoc_pkg::PD_BIT] == $past(out_pd[oi]))
    else $error("output power-down bit read back wrong");

  status_read_a: assert property (
    reg_read && reg_addr == ccoc_pkg::ADDR_STATUS
      |=> reg_rdata == {3'h0, $past(ch_run)})
    else $error("channel run status read back wrong");

  // Per output; each output trails its channel clock by one cycle
  for (genvar o = 0; o < NO; o++) begin : g_out_chk
    localparam logic [2:0] OCH = ccoc_pkg::out_channel(4'(o));

    gated_low_a: assert property (
      !$past(out_en[o]) |-> !clock_output[o])
      else $error("disabled output not held low");

    pd_low_a: assert property (
      $past(out_pd[o] || channel_power_down[OCH]) |-> !clock_output[o])
      else $error("powered-down output not held low");

    clock_follow_a: assert property (
      $past(out_en[o] && !out_pd[o] && !channel_power_down[OCH])
        |-> clock_output[o] == $past(ch_clk[OCH]))
      else $error("enabled output does not follow its channel");

    pd_merge_a: assert property (
      output_power_down[o] == $past(out_pd[o] || channel_power_down[OCH]))
      else $error("output power-down pin does not merge both levels");
  end

endmodule // ccoc_top

// *** verif/ccoc_conv_sink.sv ***
// Clock input of a downstream converter: measures high-phase lengths.
// Assumes the clock it watches is registered on clk.
`timescale 1ns/1ns
module ccoc_conv_sink (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic sclk,
  output int        high_len,
  output int        runs
);
  int cnt;

  // Count clk cycles while high; publish the length at each fall
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt      <= 0;
      high_len <= 0;
      runs     <= 0;
    end else if (sclk) begin
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      high_len <= cnt;
      runs     <= runs + 1;
      cnt      <= 0;
    end
  end
endmodule // ccoc_conv_sink

// *** verif/tb.sv ***
// Self-checking bench for the channel and clock output configuration.
// Assumes a 50 MHz clk and a one-cycle register port with no wait.
`timescale 1ns/1ns
module tb;
  logic        clk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_rdata;
  logic [9:0]  clock_output;
  logic [9:0]  output_power_down;
  logic [9:0]  output_format;
  logic [19:0] output_amplitude;
  logic [4:0]  channel_power_down;
  int          high_len;
  int          runs;
  int          err_count;
  int          compares;

  ccoc_top i_ccoc_top (
    .clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .clock_output(clock_output),
    .output_power_down(output_power_down),
    .output_format(output_format), .output_amplitude(output_amplitude),
    .channel_power_down(channel_power_down)
  );

  ccoc_conv_sink i_ccoc_conv_sink (
    .clk(clk), .reset(reset), .sclk(clock_output[0]),
    .high_len(high_len), .runs(runs)
  );

  // 20 ns clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A used-up wait bound is a mismatch and ends the run
  task automatic limit_chk(input int k, input int lim);
    if (k >= lim) begin
      err_count++;
      wrap_up();
    end
  endtask

  task automatic chk(input string nm, input logic [19:0] exp,
                     input logic [19:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bus cycles; strobes drop one edge later, so calls may follow directly
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(nm, {12'h000, e}, {12'h000, d});
  endtask

  // Output idx must stay low for n cycles
  task automatic hold_low(input int idx, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1 seen = seen | clock_output[idx];
    end
    chk("held low", 20'h00000, {19'h00000, seen});
  endtask

  task automatic t_reset();
    rd_chk("divider", 8'h20, 8'h04);
    rd_chk("phase", 8'h21, 8'h00);
    rd_chk("ch pd", 8'h22, 8'h00);
    rd_chk("out reg", 8'h24, 8'h00);
    rd_chk("enables", 8'h74, 8'h00);
    rd_chk("status", 8'h7F, 8'h1F);
    chk("out pd", 20'h00000, {10'h000, output_power_down});
    chk("format", 20'h00000, {10'h000, output_format});
    chk("amp", 20'h00000, output_amplitude);
    chk("ch pd pins", 20'h00000, {15'h0000, channel_power_down});
    hold_low(0, 40);
  endtask

  // Divider code table, including an unlisted code falling back to /6
  task automatic t_divider();
    logic [7:0] code [5] = '{8'h80, 8'h00, 8'h04, 8'h7E, 8'h05};
    int         ratio[5] = '{1, 2, 6, 160, 6};
    int         start;
    int         k;
    for (int i = 0; i < 5; i++) begin
      wr(8'h20, code[i]);
      start = runs;
      for (k = 0; k < 1200 && runs < start + 3; k++) begin
        @(posedge clk);
      end
      if (k == 1200) begin
        err_count++;
        wrap_up();
      end
      chk("high len", 20'(ratio[i]), 20'(high_len));
    end
    rd_chk("code kept", 8'h20, 8'h05);
  endtask

  // Cycles from a write of the phase code to the next rise of output B0
  task automatic rise_after(input logic [7:0] code, output int n);
    int k;
    for (k = 0; k < 200 && !(clock_output[3] === 1'b1); k++) begin
      @(posedge clk);
    end
    limit_chk(k, 200);
    for (k = 0; k < 200 && clock_output[3] !== 1'b0; k++) begin
      @(posedge clk);
    end
    limit_chk(k, 200);
    wr(8'h31, code);
    for (n = 0; n < 200 && clock_output[3] !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    limit_chk(n, 200);
  endtask

  task automatic t_phase();
    int n0;
    int n1;
    rise_after(8'h00, n0);
    rise_after(8'hFF, n1);
    chk("phase cycles", 20'h00004, 20'(n1 - n0));
    rd_chk("phase rb", 8'h31, 8'hFF);
  endtask

  task automatic t_power();
    wr(8'h22, 8'h80);
    #1 chk("ch pd pin", 20'h00001, {15'h0000, channel_power_down});
    hold_low(0, 30);
    chk("out pd A", 20'h00007, {10'h000, output_power_down});
    rd_chk("status A off", 8'h7F, 8'h1E);
    wr(8'h22, 8'h00);
    wr(8'h24, 8'h80);
    hold_low(0, 30);
    chk("out pd A0", 20'h00001, {10'h000, output_power_down});
    wr(8'h24, 8'h00);
    @(posedge clk);
    #1 chk("out pd clr", 20'h00000, {10'h000, output_power_down});
    wr(8'h74, 8'h00);
    hold_low(3, 30);
  endtask

  // Every amplitude code with LVPECL on output B0
  task automatic t_style();
    for (int a = 0; a < 4; a++) begin
      wr(8'h34, 8'h10 | 8'(a << 2));
      #1;
      chk("format B0", 20'h00001, {19'h00000, output_format[3]});
      chk("amp B0", 20'(a), {18'h00000, output_amplitude[7:6]});
    end
    wr(8'h34, 8'h00);
    #1 chk("format low", 20'h00000, {10'h000, output_format});
    wr(8'h75, 8'hFF);
    rd_chk("en hi", 8'h75, 8'h03);
  endtask

  // Unmapped place: write ignored, read zero, data stands one cycle
  task automatic t_unmapped();
    logic [7:0] d;
    wr(8'h80, 8'hFF);
    rd_chk("unmapped", 8'h80, 8'h00);
    rd(8'h20, d);
    chk("div kept", 20'h00005, {12'h000, d});
    @(posedge clk);
    #1 chk("stands", 20'h00000, {12'h000, reg_rdata});
  endtask

  initial begin
    err_count = 0;
    compares  = 0;
    reset     = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    wr(8'h74, 8'h90);
    t_divider();
    t_phase();
    t_power();
    t_style();
    t_unmapped();
    wrap_up();
  end
endmodule // tb
